//--- dsl_pkg.sv
`default_nettype none
package dsl_pkg;
	localparam int WORD_W = 16;
	localparam int CNT_W = 5;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	localparam logic [15:0] CODE_MID = 16'h8000;
	localparam logic [15:0] CODE_MSB_MASK = 16'h8000;

	// System clock and link timing, in ns
	localparam int CLK_SYS_NS = 50;
	localparam int SCLK_HALF_NS = 50;
	localparam int LOAD_DLY_NS = 30;
	localparam int LOAD_WIDTH_NS = 30;
	localparam int CS_GAP_NS = 200;

	// Least times round up to whole cycles
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int LOAD_DLY_CYC = (LOAD_DLY_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int LOAD_WIDTH_CYC = (LOAD_WIDTH_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;

	// Cycles after reset release before the strap code is applied
	localparam logic [1:0] INIT_CYC = 2'h3;
	localparam logic [1:0] INIT_LOAD_AT = 2'h1;

	localparam int BUF_DEPTH = 2;

	typedef enum logic [1:0] {
		HS_IDLE,
		HS_SHIFT,
		HS_GAP
	} dsl_host_state_t;
endpackage
`default_nettype wire

//--- dsl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dsl_link_if;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic latch_load_strobe_n;

	modport dev (
		input cs_n,
		input sclk,
		input sdi,
		input latch_load_strobe_n
	);

	modport host (
		output cs_n,
		output sclk,
		output sdi,
		output latch_load_strobe_n
	);
endinterface
`default_nettype wire

//--- dsl_dev.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_dev #(
	parameter int WORD_W = dsl_pkg::WORD_W
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_reset_value_select,
	dsl_link_if.dev link,
	output logic [WORD_W-1:0] o_input_code,
	output logic [WORD_W-1:0] o_latch_code,
	output logic o_word_taken,
	output logic o_latch_updated,
	output logic o_init_done
);

	// Link domain: runs only on the serial clock

	logic [WORD_W-1:0] shift_ff;
	logic [WORD_W-1:0] nxt_shift;

	// Older bits fall off the top, so extra clocks keep the last word
	assign nxt_shift = {shift_ff[WORD_W-2:0], link.sdi};

	always_ff @(posedge link.sclk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			shift_ff <= '0;
		else if (!link.cs_n)
			shift_ff <= nxt_shift;
	end

	// System domain: crossings of select, strobe and strap

	logic cs_s1_ff;
	logic cs_s2_ff;
	logic cs_s3_ff;
	logic load_s1_ff;
	logic load_s2_ff;
	logic sel_s1_ff;
	logic sel_s2_ff;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_s3_ff <= 1'b1;
			load_s1_ff <= 1'b1;
			load_s2_ff <= 1'b1;
			sel_s1_ff <= 1'b0;
			sel_s2_ff <= 1'b0;
		end
		else
		begin
			cs_s1_ff <= link.cs_n;
			cs_s2_ff <= cs_s1_ff;
			cs_s3_ff <= cs_s2_ff;
			load_s1_ff <= link.latch_load_strobe_n;
			load_s2_ff <= load_s1_ff;
			sel_s1_ff <= i_reset_value_select;
			sel_s2_ff <= sel_s1_ff;
		end
	end

	// Strap is caught after release, never by the reset itself

	logic [1:0] init_cnt_ff;
	logic [1:0] nxt_init_cnt;
	wire init_busy = (init_cnt_ff != 2'h0);
	wire init_load = (init_cnt_ff == dsl_pkg::INIT_LOAD_AT);

	assign nxt_init_cnt = init_busy ? init_cnt_ff - 2'h1 : init_cnt_ff;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
			init_cnt_ff <= dsl_pkg::INIT_CYC;
		else
			init_cnt_ff <= nxt_init_cnt;
	end

	wire [WORD_W-1:0] sel_code = sel_s2_ff ?
		WORD_W'(dsl_pkg::CODE_MID) : WORD_W'(dsl_pkg::CODE_ZERO);

	// Chip select rising edge, seen after the crossing
	// The shift register is still while select is high, so it is read directly;
	// the master must keep select high long enough for this edge to be seen
	wire cs_rise = cs_s2_ff && !cs_s3_ff && !init_busy;
	wire load_low = !load_s2_ff;

	logic [WORD_W-1:0] input_ff;
	logic [WORD_W-1:0] latch_ff;
	logic [WORD_W-1:0] nxt_input;
	logic [WORD_W-1:0] nxt_latch;
	logic taken_ff;
	logic updated_ff;
	logic init_done_ff;

	assign nxt_input = init_load ? sel_code :
		cs_rise ? shift_ff :
		input_ff;

	// Latch takes the incoming value so a tied-low strobe never sees a stale word
	wire latch_follow = load_low && !init_busy;
	assign nxt_latch = init_load ? sel_code :
		latch_follow ? nxt_input :
		latch_ff;

	wire latch_change = (nxt_latch != latch_ff);

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			input_ff <= WORD_W'(dsl_pkg::CODE_ZERO);
			latch_ff <= WORD_W'(dsl_pkg::CODE_ZERO);
			taken_ff <= 1'b0;
			updated_ff <= 1'b0;
			init_done_ff <= 1'b0;
		end
		else
		begin
			input_ff <= nxt_input;
			latch_ff <= nxt_latch;
			taken_ff <= cs_rise;
			updated_ff <= latch_change;
			init_done_ff <= init_done_ff || init_load;
		end
	end

	assign o_input_code = input_ff;
	assign o_latch_code = latch_ff;
	assign o_word_taken = taken_ff;
	assign o_latch_updated = updated_ff;
	assign o_init_done = init_done_ff;

endmodule
`default_nettype wire

//--- dsl_host.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_host #(
	parameter int WORD_W = dsl_pkg::WORD_W,
	parameter int HALF_CYC = dsl_pkg::SCLK_HALF_CYC,
	parameter int GAP_CYC = dsl_pkg::CS_GAP_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic [WORD_W-1:0] i_word,
	input wire logic i_word_valid,
	output logic o_word_ready,
	input wire logic i_load_pulse_mode,
	output logic o_busy,
	output logic o_sent,
	dsl_link_if.host link
);

	// Two-entry buffer in front of the serialiser

	logic [WORD_W-1:0] buf_ff [dsl_pkg::BUF_DEPTH];
	logic wr_ptr_ff;
	logic rd_ptr_ff;
	logic [1:0] count_ff;
	logic take_word;

	wire buf_full = (count_ff == 2'(dsl_pkg::BUF_DEPTH));
	wire buf_empty = (count_ff == 2'h0);
	wire push = i_word_valid && !buf_full;
	wire [1:0] nxt_count = count_ff + 2'(push) - 2'(take_word);

	assign o_word_ready = !buf_full;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff <= 2'h0;
		end
		else
		begin
			wr_ptr_ff <= wr_ptr_ff ^ push;
			rd_ptr_ff <= rd_ptr_ff ^ take_word;
			count_ff <= nxt_count;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			buf_ff[wr_ptr_ff] <= i_word;
	end

	// Serialiser: serial clock comes from a divider of the system clock

	localparam int HC_W = $clog2(HALF_CYC + 1);
	localparam int GC_W = $clog2(GAP_CYC + 1);

	dsl_pkg::dsl_host_state_t state_ff;
	dsl_pkg::dsl_host_state_t nxt_state;
	logic [WORD_W-1:0] shift_ff;
	logic [dsl_pkg::CNT_W-1:0] bit_cnt_ff;
	logic [HC_W-1:0] half_cnt_ff;
	logic [GC_W-1:0] gap_cnt_ff;
	logic sclk_ff;
	logic cs_n_ff;
	logic load_n_ff;
	logic sent_ff;

	wire tick = (half_cnt_ff == HC_W'(HALF_CYC - 1));
	wire word_done = tick && !sclk_ff && (bit_cnt_ff == dsl_pkg::CNT_W'(WORD_W));
	wire gap_done = (gap_cnt_ff == GC_W'(GAP_CYC - 1));
	wire pulse_win = (gap_cnt_ff >= GC_W'(dsl_pkg::LOAD_DLY_CYC)) &&
		(gap_cnt_ff < GC_W'(dsl_pkg::LOAD_DLY_CYC + dsl_pkg::LOAD_WIDTH_CYC));

	always_comb
	begin
		nxt_state = state_ff;
		take_word = 1'b0;
		case (state_ff)
			dsl_pkg::HS_IDLE:
			begin
				if (!buf_empty)
				begin
					take_word = 1'b1;
					nxt_state = dsl_pkg::HS_SHIFT;
				end
			end
			dsl_pkg::HS_SHIFT:
			begin
				if (word_done)
					nxt_state = dsl_pkg::HS_GAP;
			end
			dsl_pkg::HS_GAP:
			begin
				if (gap_done)
					nxt_state = dsl_pkg::HS_IDLE;
			end
			default:
				nxt_state = dsl_pkg::HS_IDLE;
		endcase
	end

	wire in_shift = (state_ff == dsl_pkg::HS_SHIFT);
	wire in_gap = (state_ff == dsl_pkg::HS_GAP);
	wire sclk_rise = in_shift && tick && !sclk_ff && !word_done;
	wire sclk_fall = in_shift && tick && sclk_ff;

	// Pulsed strobe only while deselected; otherwise held low for follow mode
	wire nxt_load_n = i_load_pulse_mode ? !(in_gap && pulse_win) : 1'b0;

	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_ff <= dsl_pkg::HS_IDLE;
			shift_ff <= '0;
			bit_cnt_ff <= '0;
			half_cnt_ff <= '0;
			gap_cnt_ff <= '0;
			sclk_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			load_n_ff <= 1'b1;
			sent_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			load_n_ff <= nxt_load_n;
			sent_ff <= word_done;
			half_cnt_ff <= (!in_shift || tick) ? '0 : half_cnt_ff + HC_W'(1);
			gap_cnt_ff <= in_gap ? gap_cnt_ff + GC_W'(1) : '0;
			if (take_word)
			begin
				shift_ff <= buf_ff[rd_ptr_ff];
				bit_cnt_ff <= '0;
				cs_n_ff <= 1'b0;
			end
			else if (word_done)
				cs_n_ff <= 1'b1;
			if (sclk_rise)
			begin
				sclk_ff <= 1'b1;
				bit_cnt_ff <= bit_cnt_ff + dsl_pkg::CNT_W'(1);
			end
			else if (sclk_fall)
			begin
				sclk_ff <= 1'b0;
				shift_ff <= {shift_ff[WORD_W-2:0], 1'b0};
			end
		end
	end

	// Divider of at least two system cycles keeps the link far below 50 Mb/s
	assign link.sclk = sclk_ff;
	assign link.cs_n = cs_n_ff;
	assign link.sdi = shift_ff[WORD_W-1];
	assign link.latch_load_strobe_n = load_n_ff;
	assign o_busy = !buf_empty || (state_ff != dsl_pkg::HS_IDLE);
	assign o_sent = sent_ff;

endmodule
`default_nettype wire

//--- dsl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dsl_checker (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_pulse_mode,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic latch_load_strobe_n
);
	logic sclk_ff;
	logic [4:0] cnt_ff;
	logic rise;
	assign rise = sclk && !sclk_ff;
	always_ff @(posedge i_clk_sys or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sclk_ff <= 1'b0;
			cnt_ff <= 5'h00;
		end
		else
		begin
			sclk_ff <= sclk;
			cnt_ff <= cs_n ? 5'h00 : cnt_ff + {4'h0, rise};
		end
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	// Tied-low strobe use is legal while selected; only pulse use must hold it high
	property p_strobe_sel; i_pulse_mode && !cs_n |-> latch_load_strobe_n; endproperty
	a_strobe_sel: assert property (p_strobe_sel)
		else $error("load strobe low while selected");
	property p_sdi_fall; $changed(sdi) |-> !sclk; endproperty
	a_sdi_fall: assert property (p_sdi_fall)
		else $error("data changed with clock high");
	property p_sclk_idle; cs_n |-> !sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle)
		else $error("serial clock high while deselected");
	property p_count; $rose(cs_n) |-> cnt_ff == 5'h10; endproperty
	a_count: assert property (p_count)
		else $error("frame without sixteen clocks");
	property p_gap; $rose(cs_n) |=> cs_n [*4]; endproperty
	a_gap: assert property (p_gap)
		else $error("select gap too short");
	property p_strobe_after; $fell(latch_load_strobe_n) |-> cs_n && $past(cs_n); endproperty
	a_strobe_after: assert property (p_strobe_after)
		else $error("strobe fell before select rose");
	property p_rise; $rose(cs_n) |-> !sclk && !$past(sclk); endproperty
	a_rise: assert property (p_rise)
		else $error("select rose with clock high");
	property p_start; $fell(cs_n) |-> !sclk ##1 !cs_n; endproperty
	a_start: assert property (p_start)
		else $error("bad frame start");
endmodule
`default_nettype wire

//--- dac_serial_load_and_reset_test.sv
`timescale 1ns/1ps
`default_nettype none
module dac_serial_load_and_reset_test;
	logic i_clk_sys = 0;
	logic i_reset_n = 0;
	logic sel = 0;
	logic pulse = 1;
	logic valid = 0;
	logic [15:0] word = 16'h0000;
	logic ready, busy, sent, tk, tk2, upd, ini;
	logic [15:0] inc, lat, inc2, lat2;
	int error_cnt = 0;
	int n_checks = 0;
	dsl_link_if lk ();
	dsl_link_if lk2 ();
	dsl_host u_dsl_host (.i_clk_sys, .i_reset_n, .i_word(word), .i_word_valid(valid),
		.o_word_ready(ready), .i_load_pulse_mode(pulse), .o_busy(busy), .o_sent(sent),
		.link(lk.host));
	dsl_dev u_dsl_dev (.i_clk_sys, .i_reset_n, .i_reset_value_select(sel), .link(lk.dev),
		.o_input_code(inc), .o_latch_code(lat), .o_word_taken(tk), .o_latch_updated(upd),
		.o_init_done(ini));
	dsl_dev u_dsl_dev_b (.i_clk_sys, .i_reset_n, .i_reset_value_select(sel), .link(lk2.dev),
		.o_input_code(inc2), .o_latch_code(lat2), .o_word_taken(tk2), .o_latch_updated(),
		.o_init_done());
	dsl_checker u_dsl_checker (.i_clk_sys, .i_reset_n, .i_pulse_mode(pulse), .cs_n(lk.cs_n),
		.sclk(lk.sclk),
		.sdi(lk.sdi), .latch_load_strobe_n(lk.latch_load_strobe_n));
	initial
		forever #25 i_clk_sys = ~i_clk_sys;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wait_ev(input int w);
		int i;
		logic s;
		i = 0;
		do
		begin
			@(posedge i_clk_sys) #5;
			s = (w == 0) ? tk : (w == 1) ? tk2 : (w == 2) ? ini : (w == 3) ? upd : sent;
			i++;
		end
		while (s !== 1'b1 && i < 200);
		chk({15'h0000, s}, 16'h0001);
	endtask
	task automatic do_reset(input logic s, input logic p);
		i_reset_n = 0;
		sel = s;
		pulse = p;
		repeat (20) @(posedge i_clk_sys);
		#5 i_reset_n = 1;
		wait_ev(2);
	endtask
	task automatic send(input logic [15:0] w);
		word = w;
		valid = 1'b1;
		while (ready !== 1'b1) @(posedge i_clk_sys) #5;
		@(posedge i_clk_sys) #5;
	endtask
	task automatic bang(input logic [31:0] b, input int n);
		lk2.cs_n = 0;
		for (int i = n - 1; i >= 0; i--)
		begin
			lk2.sdi = b[i];
			#16 lk2.sclk = 1;
			#16 lk2.sclk = 0;
		end
		// Released data line shows the inverse, not a held bit
		lk2.sdi = ~lk2.sdi;
		#16 lk2.cs_n = 1;
		wait_ev(1);
		#200;
	endtask
	initial
	begin
		lk2.cs_n = 1;
		lk2.sclk = 0;
		lk2.sdi = 0;
		lk2.latch_load_strobe_n = 0;
		do_reset(0, 1);
		chk(inc, dsl_pkg::CODE_ZERO);
		chk(lat, dsl_pkg::CODE_ZERO);
		send(16'hA5C3);
		valid = 0;
		wait_ev(4);
		chk({15'h0000, busy}, 16'h0001);
		wait_ev(0);
		chk(inc, 16'hA5C3);
		wait_ev(3);
		chk(lat, 16'hA5C3);
		bang(32'h000F1234, 20);
		chk(inc2, 16'h1234);
		chk(lat2, 16'h1234);
		lk2.sdi = 1;
		repeat (8) #16 lk2.sclk = ~lk2.sclk;
		bang(32'h0000005A, 8);
		chk(inc2, 16'h345A);
		bang(32'h0000C001, 16);
		chk(lat2, 16'hC001);
		do_reset(1, 0);
		chk(inc, dsl_pkg::CODE_MID);
		chk(lat, dsl_pkg::CODE_MID);
		chk(lat2, dsl_pkg::CODE_MID);
		send(16'h8001);
		send(16'h7FFE);
		valid = 0;
		wait_ev(0);
		chk(lat, 16'h8001);
		wait_ev(0);
		chk(inc, 16'h7FFE);
		chk(lat, 16'h7FFE);
		repeat (10) @(posedge i_clk_sys) #5;
		chk({15'h0000, busy}, 16'h0000);
		test_done();
	end
	initial
	begin
		#300000;
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
